// ==== logic/iow_pkg.sv ====
// package: register map, reset values and timing for the io watchdog controller
package iow_pkg;
    // register addresses (modbus offsets as printed)
    localparam logic [15:0] ADDR_FACTORY_DEFAULT = 16'h00E2;
    localparam logic [15:0] ADDR_REBOOT          = 16'h00E9;
    localparam logic [15:0] ADDR_LATCH_EN        = 16'h015E;
    localparam logic [15:0] ADDR_CNT_EN          = 16'h015F;
    localparam logic [15:0] ADDR_DO_PWRON        = 16'h01B3;
    localparam logic [15:0] ADDR_DO_SAFE         = 16'h0203;
    localparam logic [15:0] ADDR_CNT_PRESET      = 16'h9D08;
    localparam logic [15:0] ADDR_STATION         = 16'h9D4F;
    localparam logic [15:0] ADDR_AO_SAFE         = 16'h9DC8;
    localparam logic [15:0] ADDR_AO_RANGE        = 16'h9E0B;
    localparam logic [15:0] ADDR_AO_SLEW         = 16'h9E4B;
    localparam logic [15:0] ADDR_RESET_CAUSE     = 16'h9E6B;
    localparam logic [15:0] ADDR_RESET_COUNT     = 16'h9E6C;
    localparam logic [15:0] ADDR_WDT_TIMEOUT     = 16'h9E6D;
    localparam logic [15:0] ADDR_WDT_COUNT       = 16'h9E6E;
    // own choices: counter value words, latch status, power-on and live analogue values
    localparam logic [15:0] ADDR_CNT_VALUE       = 16'h9F00;
    localparam logic [15:0] ADDR_LATCH_STATUS    = 16'h0400;
    localparam logic [15:0] ADDR_AO_PWRON        = 16'h9F40;
    localparam logic [15:0] ADDR_AO_LEVEL        = 16'h9F80;
    // reset cause codes
    localparam logic [15:0] CAUSE_POWER_ON  = 16'h0001;
    localparam logic [15:0] CAUSE_INT_WDT   = 16'h0002;
    localparam logic [15:0] CAUSE_RESET_CMD = 16'h0003;
    // reset values and limits
    localparam logic [15:0] STATION_RESET   = 16'h0001;
    localparam logic [15:0] WDT_TIMEOUT_RST = 16'h0000;
    localparam logic [15:0] WDT_MIN_SECONDS = 16'h0006;
    localparam logic [15:0] AO_RANGE_RESET  = 16'h0020;
    localparam logic [31:0] PRESET_MAX      = 32'hFFFFFFFE;
    // timing: one second at 20 MHz
    localparam int unsigned CLK_HZ          = 20000000;
    localparam int unsigned SECOND_S        = 1;
    localparam int unsigned SECOND_CYCLES   = SECOND_S * CLK_HZ;
    // slew: cycles between one-step moves for each unit of slew setting
    localparam int unsigned SLEW_TICK_CYCLES = 20;
endpackage

// ==== logic/iow_ao_if.sv ====
// interface: per-channel analogue output target and slew setting to the ramp unit
`timescale 1ns/1ps
`default_nettype none
interface iow_ao_if #(parameter int W = 16);
    logic [W-1:0] target;
    logic [15:0]  slew;
    logic         load;
    logic [W-1:0] level;
    modport ctrl (output target, output slew, output load, input level);
    modport ramp (input target, input slew, input load, output level);
endinterface
`default_nettype wire

// ==== logic/iow_ao_ramp.sv ====
// module: slew-limited analogue output ramp for one channel
`timescale 1ns/1ps
`default_nettype none
module iow_ao_ramp #(
    parameter int W = 16
) (
    input  wire logic ref_clk_i,
    input  wire logic nrst_i,
    iow_ao_if.ramp    ao
);
    typedef struct packed {
        logic [W-1:0] level;
        logic [31:0]  tick;
    } iow_ramp_st_t;

    iow_ramp_st_t st_reg;
    iow_ramp_st_t st_next;

    // one step toward target per slew period; slew 0 jumps at once
    always_comb begin
        st_next = st_reg;
        if (ao.load || ao.slew == 16'h0000) begin
            st_next.level = ao.target;
            st_next.tick  = 32'h0;
        end else if (st_reg.level != ao.target) begin
            if (st_reg.tick >= ao.slew * iow_pkg::SLEW_TICK_CYCLES) begin
                st_next.tick  = 32'h0;
                st_next.level = (st_reg.level < ao.target) ? st_reg.level + 1'b1
                                                           : st_reg.level - 1'b1;
            end else begin
                st_next.tick = st_reg.tick + 32'h1;
            end
        end
    end

    // level starts at zero; first load places the power-on value
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign ao.level = st_reg.level;
endmodule
`default_nettype wire

// ==== logic/iow_ctrl.sv ====
// module: host watchdog, reset cause, counters, latches and output control
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - watchdog timeout zero disables; 6 to 65535 seconds enables; default zero
// - last reset cause kept: 1 power-on, 2 internal watchdog, 3 command
// - factory-default command restores every setting to default
// - switched outputs drive zero at start-up; reset clears their power-on bit first
// - on host loss with watchdog on, switched outputs drive safe bits
// - each binary input counter is 32 bits, read as low and high word
// - enabled channel counts input pulses into its counter
// - with latch enabled, any input change is held until host clears
// - each analogue output has its own range code
// - analogue output slews per setting; zero changes at once
// - analogue outputs drive zero at start-up; reset clears their power-on value first
// - on host loss with watchdog on, analogue outputs drive safe values
module iow_ctrl #(
    parameter int          NDI    = 2,
    parameter int          NDO    = 2,
    parameter int          NAO    = 2,
    parameter int unsigned SEC_CY = iow_pkg::SECOND_CYCLES
) (
    input  wire logic             ref_clk_i,
    input  wire logic             nrst_i,
    input  wire logic [1:0]       reset_cause_i,
    input  wire logic             reg_wr_i,
    input  wire logic             reg_rd_i,
    input  wire logic [15:0]      reg_addr_i,
    input  wire logic [15:0]      reg_wdata_i,
    output logic      [15:0]      reg_rdata_o,
    output logic                  reg_err_o,
    input  wire logic             host_txn_i,
    input  wire logic [NDI-1:0]   bin_in_i,
    output logic      [NDO-1:0]   sw_out_o,
    output logic      [NAO*16-1:0] ao_level_o,
    output logic      [NAO*16-1:0] ao_range_o,
    output logic                  host_lost_o,
    output logic                  reboot_req_o
);
    typedef struct packed {
        logic [15:0]          wdt_timeout;
        logic [31:0]          wdt_cycles;
        logic [15:0]          wdt_secs;
        logic                 lost;
        logic [15:0]          wdt_count;
        logic [15:0]          reset_cause;
        logic [15:0]          reset_count;
        logic                 started;
        logic [15:0]          station;
        logic                 latch_en;
        logic [NDI-1:0]       cnt_en;
        logic [NDI-1:0]       latch_st;
        logic [NDI-1:0]       in_prev;
        logic [NDI*32-1:0]    preset;
        logic [NDI*32-1:0]    count;
        logic [NDO-1:0]       do_pwron;
        logic [NDO-1:0]       do_safe;
        logic [NDO-1:0]       do_val;
        logic [NAO*16-1:0]    ao_pwron;
        logic [NAO*16-1:0]    ao_safe;
        logic [NAO*16-1:0]    ao_val;
        logic [NAO*16-1:0]    ao_range;
        logic [NAO*16-1:0]    ao_slew;
        logic                 ao_load;
        logic                 reboot;
        logic [15:0]          rdata;
        logic                 err;
    } iow_st_t;

    iow_st_t st_reg;
    iow_st_t st_next;
    logic [NAO*16-1:0] ao_lvl;

    // per analogue channel ramp units
    for (genvar g = 0; g < NAO; g++) begin : g_ao
        iow_ao_if #(.W(16)) aoi ();
        assign aoi.target = st_reg.lost ? st_reg.ao_safe[g*16 +: 16]
                                        : st_reg.ao_val[g*16 +: 16];
        assign aoi.slew   = st_reg.ao_slew[g*16 +: 16];
        assign aoi.load   = st_reg.ao_load;
        assign ao_lvl[g*16 +: 16] = aoi.level;
        iow_ao_ramp #(.W(16)) u_ramp (
            .ref_clk_i (ref_clk_i),
            .nrst_i    (nrst_i),
            .ao        (aoi.ramp)
        );
    end

    // factory defaults, used by the default command; reset loads the same values itself
    function automatic iow_st_t defaults(input iow_st_t s);
        iow_st_t d;
        d = s;
        d.wdt_timeout = iow_pkg::WDT_TIMEOUT_RST;
        d.station     = iow_pkg::STATION_RESET;
        d.latch_en    = 1'b0;
        d.cnt_en      = '0;
        d.preset      = '0;
        d.do_pwron    = '0;
        d.do_safe     = '0;
        d.ao_pwron    = '0;
        d.ao_safe     = '0;
        d.ao_slew     = '0;
        d.wdt_count   = 16'h0000;
        d.lost        = 1'b0;
        d.wdt_secs    = 16'h0000;
        d.wdt_cycles  = 32'h0;
        for (int i = 0; i < NAO; i++) begin
            d.ao_range[i*16 +: 16] = iow_pkg::AO_RANGE_RESET;
        end
        return d;
    endfunction

    // register access, watchdog, counters, latches
    always_comb begin
        logic [31:0] pv;
        logic [15:0] idx;
        logic        hit;
        pv          = 32'h0;
        idx         = 16'h0000;
        hit         = 1'b0;
        st_next     = st_reg;
        st_next.ao_load = 1'b0;
        st_next.reboot  = 1'b0;
        st_next.err     = 1'b0;
        // start-up: record cause, bump reset counter, load power-on values
        if (!st_reg.started) begin
            st_next.started     = 1'b1;
            st_next.reset_cause = {14'h0000, reset_cause_i};
            st_next.reset_count = st_reg.reset_count + 16'h0001;
            st_next.do_val      = st_reg.do_pwron;
            st_next.ao_val      = st_reg.ao_pwron;
            st_next.ao_load     = 1'b1;
        end
        // host watchdog: seconds of silence against the timeout
        if (host_txn_i) begin
            st_next.wdt_cycles = 32'h0;
            st_next.wdt_secs   = 16'h0000;
            st_next.lost       = 1'b0;
        end else if (st_reg.wdt_timeout >= iow_pkg::WDT_MIN_SECONDS && !st_reg.lost) begin
            if (st_reg.wdt_cycles == SEC_CY - 1) begin
                st_next.wdt_cycles = 32'h0;
                st_next.wdt_secs   = st_reg.wdt_secs + 16'h0001;
                if (st_reg.wdt_secs + 16'h0001 >= st_reg.wdt_timeout) begin
                    st_next.lost      = 1'b1;
                    st_next.wdt_count = st_reg.wdt_count + 16'h0001;
                end
            end else begin
                st_next.wdt_cycles = st_reg.wdt_cycles + 32'h1;
            end
        end else if (st_reg.wdt_timeout < iow_pkg::WDT_MIN_SECONDS) begin
            st_next.lost = 1'b0;
        end
        // input latch and pulse counters, per channel
        for (int i = 0; i < NDI; i++) begin
            if (bin_in_i[i] != st_reg.in_prev[i] && st_reg.latch_en) begin
                st_next.latch_st[i] = 1'b1;
            end
            if (st_reg.cnt_en[i] && bin_in_i[i] && !st_reg.in_prev[i]) begin
                st_next.count[i*32 +: 32] = st_reg.count[i*32 +: 32] + 32'h1;
            end
        end
        st_next.in_prev = bin_in_i;
        // register writes
        if (reg_wr_i) begin
            hit = 1'b1;
            unique case (reg_addr_i)
                iow_pkg::ADDR_FACTORY_DEFAULT: if (reg_wdata_i[0]) st_next = defaults(st_next);
                iow_pkg::ADDR_REBOOT:      st_next.reboot   = reg_wdata_i[0];
                iow_pkg::ADDR_LATCH_EN:    st_next.latch_en = reg_wdata_i[0];
                iow_pkg::ADDR_STATION:     st_next.station  = reg_wdata_i;
                iow_pkg::ADDR_WDT_TIMEOUT: st_next.wdt_timeout = reg_wdata_i;
                iow_pkg::ADDR_WDT_COUNT:   st_next.wdt_count = 16'h0000;
                default: begin
                    hit = 1'b0;
                    for (int i = 0; i < NDI; i++) begin
                        idx = 16'(i);
                        if (reg_addr_i == iow_pkg::ADDR_CNT_EN + idx) begin
                            st_next.cnt_en[i] = reg_wdata_i[0];
                            hit = 1'b1;
                        end
                        // latch clear: host write clears, a same-cycle change still sets
                        if (reg_addr_i == iow_pkg::ADDR_LATCH_STATUS + idx) begin
                            st_next.latch_st[i] = st_reg.latch_en
                                && bin_in_i[i] != st_reg.in_prev[i];
                            hit = 1'b1;
                        end
                        for (int w = 0; w < 2; w++) begin
                            if (reg_addr_i == iow_pkg::ADDR_CNT_PRESET + 16'(2*i + w)) begin
                                pv = st_next.preset[i*32 +: 32];
                                pv[w*16 +: 16] = reg_wdata_i;
                                if (pv <= iow_pkg::PRESET_MAX) begin
                                    st_next.preset[i*32 +: 32] = pv;
                                    st_next.count[i*32 +: 32]  = pv;
                                end
                                hit = 1'b1;
                            end
                        end
                    end
                    for (int i = 0; i < NDO; i++) begin
                        idx = 16'(i);
                        if (reg_addr_i == iow_pkg::ADDR_DO_PWRON + idx) begin
                            st_next.do_pwron[i] = reg_wdata_i[0];
                            hit = 1'b1;
                        end
                        if (reg_addr_i == iow_pkg::ADDR_DO_SAFE + idx) begin
                            st_next.do_safe[i] = reg_wdata_i[0];
                            hit = 1'b1;
                        end
                    end
                    for (int i = 0; i < NAO; i++) begin
                        idx = 16'(i);
                        if (reg_addr_i == iow_pkg::ADDR_AO_SAFE + idx) begin
                            st_next.ao_safe[i*16 +: 16] = reg_wdata_i;
                            hit = 1'b1;
                        end
                        if (reg_addr_i == iow_pkg::ADDR_AO_RANGE + idx) begin
                            st_next.ao_range[i*16 +: 16] = reg_wdata_i;
                            hit = 1'b1;
                        end
                        if (reg_addr_i == iow_pkg::ADDR_AO_SLEW + idx) begin
                            st_next.ao_slew[i*16 +: 16] = reg_wdata_i;
                            hit = 1'b1;
                        end
                        if (reg_addr_i == iow_pkg::ADDR_AO_PWRON + idx) begin
                            st_next.ao_pwron[i*16 +: 16] = reg_wdata_i;
                            hit = 1'b1;
                        end
                        if (reg_addr_i == iow_pkg::ADDR_AO_LEVEL + idx) begin
                            st_next.ao_val[i*16 +: 16] = reg_wdata_i;
                            hit = 1'b1;
                        end
                    end
                    for (int i = 0; i < NDO; i++) begin
                        if (reg_addr_i == 16'(i)) begin
                            st_next.do_val[i] = reg_wdata_i[0];
                            hit = 1'b1;
                        end
                    end
                end
            endcase
            st_next.err = !hit;
        end
        // register reads, answered one cycle later
        if (reg_rd_i) begin
            hit = 1'b1;
            st_next.rdata = 16'h0000;
            unique case (reg_addr_i)
                iow_pkg::ADDR_LATCH_EN:    st_next.rdata = {15'h0000, st_reg.latch_en};
                iow_pkg::ADDR_STATION:     st_next.rdata = st_reg.station;
                iow_pkg::ADDR_RESET_CAUSE: st_next.rdata = st_reg.reset_cause;
                iow_pkg::ADDR_RESET_COUNT: st_next.rdata = st_reg.reset_count;
                iow_pkg::ADDR_WDT_TIMEOUT: st_next.rdata = st_reg.wdt_timeout;
                iow_pkg::ADDR_WDT_COUNT:   st_next.rdata = st_reg.wdt_count;
                default: begin
                    hit = 1'b0;
                    for (int i = 0; i < NDI; i++) begin
                        idx = 16'(i);
                        if (reg_addr_i == iow_pkg::ADDR_CNT_EN + idx) begin
                            st_next.rdata = {15'h0000, st_reg.cnt_en[i]};
                            hit = 1'b1;
                        end
                        if (reg_addr_i == iow_pkg::ADDR_LATCH_STATUS + idx) begin
                            st_next.rdata = {15'h0000, st_reg.latch_st[i]};
                            hit = 1'b1;
                        end
                        for (int w = 0; w < 2; w++) begin
                            if (reg_addr_i == iow_pkg::ADDR_CNT_PRESET + 16'(2*i + w)) begin
                                st_next.rdata = st_reg.preset[i*32 + w*16 +: 16];
                                hit = 1'b1;
                            end
                            if (reg_addr_i == iow_pkg::ADDR_CNT_VALUE + 16'(2*i + w)) begin
                                st_next.rdata = st_reg.count[i*32 + w*16 +: 16];
                                hit = 1'b1;
                            end
                        end
                    end
                    for (int i = 0; i < NDO; i++) begin
                        idx = 16'(i);
                        if (reg_addr_i == iow_pkg::ADDR_DO_PWRON + idx) begin
                            st_next.rdata = {15'h0000, st_reg.do_pwron[i]};
                            hit = 1'b1;
                        end
                        if (reg_addr_i == iow_pkg::ADDR_DO_SAFE + idx) begin
                            st_next.rdata = {15'h0000, st_reg.do_safe[i]};
                            hit = 1'b1;
                        end
                    end
                    for (int i = 0; i < NAO; i++) begin
                        idx = 16'(i);
                        if (reg_addr_i == iow_pkg::ADDR_AO_SAFE + idx) begin
                            st_next.rdata = st_reg.ao_safe[i*16 +: 16];
                            hit = 1'b1;
                        end
                        if (reg_addr_i == iow_pkg::ADDR_AO_RANGE + idx) begin
                            st_next.rdata = st_reg.ao_range[i*16 +: 16];
                            hit = 1'b1;
                        end
                        if (reg_addr_i == iow_pkg::ADDR_AO_SLEW + idx) begin
                            st_next.rdata = st_reg.ao_slew[i*16 +: 16];
                            hit = 1'b1;
                        end
                        if (reg_addr_i == iow_pkg::ADDR_AO_PWRON + idx) begin
                            st_next.rdata = st_reg.ao_pwron[i*16 +: 16];
                            hit = 1'b1;
                        end
                        if (reg_addr_i == iow_pkg::ADDR_AO_LEVEL + idx) begin
                            st_next.rdata = ao_lvl[i*16 +: 16];
                            hit = 1'b1;
                        end
                    end
                end
            endcase
            st_next.err = !hit;
        end
    end

    // settings take defaults at reset; cause and reset count come from start-up
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_reg             <= '0;
            st_reg.station     <= iow_pkg::STATION_RESET;
            st_reg.wdt_timeout <= iow_pkg::WDT_TIMEOUT_RST;
            for (int i = 0; i < NAO; i++) begin
                st_reg.ao_range[i*16 +: 16] <= iow_pkg::AO_RANGE_RESET;
            end
        end else begin
            st_reg <= st_next;
        end
    end

    // safe values replace live ones while the host is lost
    assign sw_out_o     = st_reg.lost ? st_reg.do_safe : st_reg.do_val;
    assign ao_level_o   = ao_lvl;
    assign ao_range_o   = st_reg.ao_range;
    assign host_lost_o  = st_reg.lost;
    assign reboot_req_o = st_reg.reboot;
    assign reg_rdata_o  = st_reg.rdata;
    assign reg_err_o    = st_reg.err;
endmodule
`default_nettype wire

// ==== testbench/iow_ctrl_assertions.sv ====
// checker: port-level properties of the io watchdog controller
`timescale 1ns/1ps
`default_nettype none
module iow_ctrl_assertions #(
    parameter int          NDI    = 2,
    parameter int          NDO    = 2,
    parameter int          NAO    = 2,
    parameter int unsigned SEC_CY = 10
) (
    input wire logic              ref_clk_i,
    input wire logic              nrst_i,
    input wire logic [1:0]        reset_cause_i,
    input wire logic              reg_wr_i,
    input wire logic              reg_rd_i,
    input wire logic [15:0]       reg_addr_i,
    input wire logic [15:0]       reg_wdata_i,
    input wire logic [15:0]       reg_rdata_o,
    input wire logic              host_txn_i,
    input wire logic [NDO-1:0]    sw_out_o,
    input wire logic [NAO*16-1:0] ao_range_o,
    input wire logic              host_lost_o,
    input wire logic              reboot_req_o
);
    logic [15:0]    wdt_q;
    logic [NDO-1:0] safe_q;
    logic [1:0]     cause_q;
    logic           first_q;
    int unsigned    quiet_q;
    wire logic      wa_w = reg_wr_i && !reg_rd_i;
    wire logic      rb_w = wa_w && reg_addr_i == iow_pkg::ADDR_REBOOT && reg_wdata_i[0];
    // shadow of the few settings the properties need; cleared like the device
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wdt_q   <= 16'h0000;
            safe_q  <= '0;
            cause_q <= 2'h0;
            first_q <= 1'b1;
            quiet_q <= 0;
        end else begin
            first_q <= 1'b0;
            quiet_q <= host_txn_i ? 0 : quiet_q + 1;
            if (first_q) cause_q <= reset_cause_i;
            if (wa_w && reg_addr_i == iow_pkg::ADDR_WDT_TIMEOUT) wdt_q <= reg_wdata_i;
            for (int i = 0; i < NDO; i++) begin
                if (wa_w && reg_addr_i == iow_pkg::ADDR_DO_SAFE + 16'(i)) safe_q[i] <= reg_wdata_i[0];
            end
            if (wa_w && reg_addr_i == iow_pkg::ADDR_FACTORY_DEFAULT && reg_wdata_i[0]) begin
                wdt_q  <= 16'h0000;
                safe_q <= '0;
            end
        end
    end
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);
    property p_wdt_off; wdt_q == 16'h0000 |-> !$rose(host_lost_o); endproperty
    a_wdt_off: assert property (p_wdt_off) else $error("watchdog fired while off");
    property p_wdt_min; $rose(host_lost_o) |-> quiet_q == wdt_q * SEC_CY; endproperty
    a_wdt_min: assert property (p_wdt_min) else $error("watchdog fired too early");
    property p_txn; host_txn_i |=> !host_lost_o; endproperty
    a_txn: assert property (p_txn) else $error("host loss survived a transaction");
    property p_cause;
        reg_rd_i && reg_addr_i == iow_pkg::ADDR_RESET_CAUSE |=> reg_rdata_o == {14'h0, cause_q};
    endproperty
    a_cause: assert property (p_cause) else $error("wrong reset cause read");
    property p_range;
        wa_w && reg_addr_i == iow_pkg::ADDR_AO_RANGE |=> ao_range_o[15:0] == $past(reg_wdata_i);
    endproperty
    a_range: assert property (p_range) else $error("range code not applied");
    property p_safe; host_lost_o |-> sw_out_o == safe_q; endproperty
    a_safe: assert property (p_safe) else $error("switched outputs not safe");
    property p_reboot; reboot_req_o |-> $past(rb_w); endproperty
    a_reboot: assert property (p_reboot) else $error("reboot without command");
    property p_hold; !reg_rd_i |=> $stable(reg_rdata_o); endproperty
    a_hold: assert property (p_hold) else $error("read data moved without read");
    c_lost: cover property ($rose(host_lost_o));
    c_reboot: cover property (reboot_req_o);
    c_cause: cover property (reg_rd_i && reg_addr_i == iow_pkg::ADDR_RESET_CAUSE);
endmodule
bind iow_ctrl iow_ctrl_assertions #(.NDI(NDI), .NDO(NDO), .NAO(NAO), .SEC_CY(SEC_CY)) chk (
    .ref_clk_i, .nrst_i, .reset_cause_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i,
    .reg_rdata_o, .host_txn_i, .sw_out_o, .ao_range_o, .host_lost_o, .reboot_req_o);
`default_nettype wire

// ==== testbench/iow_host.sv ====
// partner: host pc model issuing register accesses with transaction pulses
`timescale 1ns/1ps
`default_nettype none
module iow_host (
    input  wire logic        ref_clk_i,
    input  wire logic [15:0] rdata_i,
    output logic             wr_o,
    output logic             rd_o,
    output logic             txn_o,
    output logic [15:0]      addr_o,
    output logic [15:0]      wdata_o
);
    initial begin
        wr_o = 1'b0;
        rd_o = 1'b0;
        txn_o = 1'b0;
        addr_o = 16'h0000;
        wdata_o = 16'h0000;
    end
    // one access per call; released lines show inverted garbage, not old values
    task automatic access(input logic w, input logic [15:0] a, d, output logic [15:0] q);
        @(posedge ref_clk_i);
        wr_o <= w;
        rd_o <= !w;
        txn_o <= 1'b1;
        addr_o <= a;
        wdata_o <= d;
        @(posedge ref_clk_i);
        wr_o <= 1'b0;
        rd_o <= 1'b0;
        txn_o <= 1'b0;
        addr_o <= ~a;
        wdata_o <= ~d;
        #1 q = rdata_i;
    endtask
endmodule
`default_nettype wire

// ==== testbench/tb.sv ====
// testbench: register-level scenarios for the io watchdog controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fails++; \
    $display("BAD %0t got %h want %h", $time, (a), (b)); end end
module tb;
    logic        ref_clk_i = 1'b0;
    logic        nrst_i    = 1'b0;
    logic [1:0]  cause     = 2'h1, bin = 2'h0;
    logic        wr, rd, txn, err, lost, rbt;
    logic [15:0] addr, wdata, rdata, q;
    logic [1:0]  sw;
    logic [31:0] lvl, rng;
    int          fails = 0;
    int          total_checks = 0;
    always #25 ref_clk_i = ~ref_clk_i;
    iow_host host (.ref_clk_i, .rdata_i(rdata), .wr_o(wr), .rd_o(rd), .txn_o(txn),
        .addr_o(addr), .wdata_o(wdata));
    // short second so the watchdog expires within tens of cycles
    iow_ctrl #(.SEC_CY(10)) dut (.ref_clk_i, .nrst_i, .reset_cause_i(cause), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
        .reg_err_o(err), .host_txn_i(txn), .bin_in_i(bin), .sw_out_o(sw), .ao_level_o(lvl),
        .ao_range_o(rng), .host_lost_o(lost), .reboot_req_o(rbt));
    task wrr(input logic [15:0] a, d);
        host.access(1'b1, a, d, q);
    endtask
    task rdc(input logic [15:0] a, e);
        host.access(1'b0, a, 16'h0000, q);
        `CHK(q, e)
    endtask
    task idle(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask
    task rst(input logic [1:0] c);
        @(posedge ref_clk_i) nrst_i <= 1'b0;
        cause <= c;
        repeat (2) @(posedge ref_clk_i);
        nrst_i <= 1'b1;
        idle(2);
    endtask
    task summarize;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge ref_clk_i);
        fails++;
        summarize();
    end
    initial begin
        rst(2'h1);
        rdc(iow_pkg::ADDR_WDT_TIMEOUT, iow_pkg::WDT_TIMEOUT_RST);
        `CHK(rng, {2{iow_pkg::AO_RANGE_RESET}})
        `CHK(sw, 2'h0)
        `CHK(lvl, 32'h0000_0000)
        host.access(1'b0, 16'h7777, 16'h0000, q);
        `CHK(err, 1'b1)
        idle(100);
        `CHK(lost, 1'b0)
        wrr(iow_pkg::ADDR_DO_SAFE, 16'h0001);
        wrr(iow_pkg::ADDR_AO_SAFE, 16'h1234);
        wrr(iow_pkg::ADDR_WDT_TIMEOUT, 16'h0006);
        idle(50);
        rdc(iow_pkg::ADDR_WDT_TIMEOUT, 16'h0006);
        idle(50);
        `CHK(lost, 1'b0)
        idle(20);
        `CHK(lost, 1'b1)
        `CHK(sw, 2'h1)
        `CHK(lvl[15:0], 16'h1234)
        rdc(iow_pkg::ADDR_WDT_COUNT, 16'h0001);
        idle(2);
        `CHK(lost, 1'b0)
        wrr(iow_pkg::ADDR_CNT_EN, 16'h0001);
        wrr(iow_pkg::ADDR_LATCH_EN, 16'h0001);
        wrr(iow_pkg::ADDR_CNT_PRESET + 16'h0001, 16'hFFFF);
        wrr(iow_pkg::ADDR_CNT_PRESET, 16'hFFFF);
        rdc(iow_pkg::ADDR_CNT_PRESET, 16'h0000);
        wrr(iow_pkg::ADDR_CNT_PRESET, 16'hFFFE);
        wrr(iow_pkg::ADDR_CNT_PRESET + 16'h0001, 16'h0000);
        repeat (3) begin
            @(posedge ref_clk_i) bin <= 2'h3;
            @(posedge ref_clk_i) bin <= 2'h0;
        end
        rdc(iow_pkg::ADDR_CNT_VALUE, 16'h0001);
        rdc(iow_pkg::ADDR_CNT_VALUE + 16'h0001, 16'h0001);
        rdc(iow_pkg::ADDR_LATCH_STATUS + 16'h0001, 16'h0001);
        wrr(iow_pkg::ADDR_LATCH_STATUS + 16'h0001, 16'h0000);
        rdc(iow_pkg::ADDR_LATCH_STATUS + 16'h0001, 16'h0000);
        wrr(iow_pkg::ADDR_AO_RANGE, 16'h0030);
        idle(1);
        `CHK(rng, {iow_pkg::AO_RANGE_RESET, 16'h0030})
        wrr(iow_pkg::ADDR_STATION, 16'h0005);
        wrr(iow_pkg::ADDR_FACTORY_DEFAULT, 16'h0001);
        idle(2);
        rdc(iow_pkg::ADDR_STATION, iow_pkg::STATION_RESET);
        rdc(iow_pkg::ADDR_LATCH_EN, 16'h0000);
        rdc(iow_pkg::ADDR_WDT_TIMEOUT, 16'h0000);
        wrr(iow_pkg::ADDR_REBOOT, 16'h0001);
        `CHK(rbt, 1'b1)
        for (int c = 1; c < 4; c++) begin
            rst(c[1:0]);
            rdc(iow_pkg::ADDR_RESET_CAUSE, {14'h0, c[1:0]});
        end
        summarize();
    end
endmodule
`default_nettype wire
